// ==== common/cbdu_defines.svh ====
`ifndef CBDU_DEFINES_SVH
`define CBDU_DEFINES_SVH

// Instruction word field positions
`define CBDU_FIRST_IDX_HI   31
`define CBDU_FIRST_IDX_LO   27
`define CBDU_SECOND_IDX_HI  26
`define CBDU_SECOND_IDX_LO  22
`define CBDU_OFFSET_HI      21
`define CBDU_OFFSET_LO      6
`define CBDU_OPCODE_HI      5
`define CBDU_OPCODE_LO      0

// Primary opcodes
`define CBDU_OP_LESS_UNSIGNED 6'h36
`define CBDU_OP_NOT_EQUAL     6'h1e

// Sequential step in bytes
`define CBDU_PC_STEP 32'h00000004

// Reset values
`define CBDU_PC_RESET 32'h00000000

`endif

// ==== common/cbdu_pkg.sv ====
package cbdu_pkg;

  typedef enum logic [1:0] {
    CBDU_IDLE   = 2'b00,
    CBDU_RESULT = 2'b01,
    CBDU_FAULT  = 2'b11
  } cbdu_state_type;

  typedef enum logic [1:0] {
    CBDU_KIND_NONE = 2'h0,
    CBDU_KIND_LTU  = 2'h1,
    CBDU_KIND_NE   = 2'h2
  } cbdu_kind_type;

endpackage

// ==== rtl/cbdu_compare.sv ====
`timescale 1ns/100ps
module cbdu_compare
  import cbdu_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic [WIDTH-1:0] firstSourceOperand,   // Operand selected by first index
  input  wire logic [WIDTH-1:0] secondSourceOperand,  // Operand selected by second index
  output logic                  lessUnsigned,         // First below second, unsigned
  output logic                  notEqual              // Operands differ in any bit
);

  always_comb begin
    lessUnsigned = firstSourceOperand < secondSourceOperand;
    notEqual     = firstSourceOperand != secondSourceOperand;
  end

endmodule

// ==== rtl/cbdu_branch_unit.sv ====
// How it works
// [RULE1] Opcode 0x36 branches when first operand is unsigned-less than second.
// [RULE2] Opcode 0x1e branches when operands differ in any bit.
// [RULE3] Taken unsigned branch target is instruction address plus 4 plus offset.
// [RULE4] Taken not-equal target is branch address plus 4 plus offset.
// [RULE5] Software keeps low two offset bits zero for word-aligned targets.
// [RULE6] A taken branch to an unaligned address raises misaligned exception.
// [RULE7] Both decode as immediate type with two source register indices.
// [RULE8] Offset is 16-bit two's complement, sign-extended to 32 bits.
// [RULE9] Fields: first index 31:27, second 26:22, offset 21:6, opcode 5:0.
// [RULE10] Nonzero low target bits suppress the PC update and flag exception.
`timescale 1ns/100ps
`include "cbdu_defines.svh"
module cbdu_branch_unit
  import cbdu_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk,                 // Processor clock
  input  wire logic             rst_n,                // Async reset, active low
  input  wire logic             instrValid,           // Instruction word present
  input  wire logic [31:0]      instrWord,            // Instruction word
  input  wire logic [WIDTH-1:0] instrAddr,            // Address of this instruction
  input  wire logic [WIDTH-1:0] firstSourceOperand,   // Value of first source register
  input  wire logic [WIDTH-1:0] secondSourceOperand,  // Value of second source register
  output logic [4:0]            firstIndex,           // First source register index
  output logic [4:0]            secondIndex,          // Second source register index
  output logic                  isBranch,             // Word is one of the two branches
  output logic                  pcValid,              // Pulse: nextPc holds a new PC
  output logic [WIDTH-1:0]      nextPc,               // Registered next program counter
  output logic                  branchTaken,          // Registered: branch was taken
  output logic                  misalignedFault       // Pulse: misaligned destination
);

  logic [5:0]       opcode;
  logic [15:0]      branchOffsetField;
  logic [WIDTH-1:0] offsetExt;
  logic [WIDTH-1:0] seqAddr;
  logic [WIDTH-1:0] target;
  logic             lessUnsigned;
  logic             notEqual;
  logic             takeCond;
  cbdu_kind_type    kind;

  cbdu_state_type   state;
  cbdu_state_type   next_state;
  logic [WIDTH-1:0] next_nextPc;
  logic             next_branchTaken;

  // [RULE7] [RULE9] field split
  always_comb begin
    firstIndex        = instrWord[`CBDU_FIRST_IDX_HI:`CBDU_FIRST_IDX_LO];
    secondIndex       = instrWord[`CBDU_SECOND_IDX_HI:`CBDU_SECOND_IDX_LO];
    branchOffsetField = instrWord[`CBDU_OFFSET_HI:`CBDU_OFFSET_LO];
    opcode            = instrWord[`CBDU_OPCODE_HI:`CBDU_OPCODE_LO];
  end

  always_comb begin
    case (opcode)
      `CBDU_OP_LESS_UNSIGNED: kind = CBDU_KIND_LTU;
      `CBDU_OP_NOT_EQUAL:     kind = CBDU_KIND_NE;
      default:                kind = CBDU_KIND_NONE;
    endcase
    isBranch = instrValid && (kind != CBDU_KIND_NONE);
  end

  cbdu_compare #(
    .WIDTH(WIDTH)
  ) u_compare (
    .firstSourceOperand (firstSourceOperand),
    .secondSourceOperand(secondSourceOperand),
    .lessUnsigned       (lessUnsigned),
    .notEqual           (notEqual)
  );

  // Offset is widened first so a negative step borrows across the full address
  // [RULE8] sign extension
  assign offsetExt = {{(WIDTH-16){branchOffsetField[15]}}, branchOffsetField};

  // Sums wrap modulo 2^WIDTH; the carry out is dropped on purpose
  // [RULE3] [RULE4] sequential base then offset
  always_comb begin
    seqAddr = instrAddr + WIDTH'(`CBDU_PC_STEP);
    target  = seqAddr + offsetExt;
  end

  // [RULE1] [RULE2] condition select
  always_comb begin
    case (kind)
      CBDU_KIND_LTU: takeCond = lessUnsigned;
      CBDU_KIND_NE:  takeCond = notEqual;
      default:       takeCond = 1'b0;
    endcase
  end

  // Fault keeps nextPc, so the handler still sees the last good destination.
  // Untaken branches never fault, whatever the offset holds.
  // [RULE6] [RULE10] unaligned target faults instead of updating PC
  always_comb begin
    next_state       = CBDU_IDLE;
    next_nextPc      = nextPc;
    next_branchTaken = 1'b0;
    if (isBranch) begin
      if (takeCond && (target[1:0] != 2'b00)) begin
        next_state = CBDU_FAULT;
      end else begin
        next_state       = CBDU_RESULT;
        next_branchTaken = takeCond;
        next_nextPc      = takeCond ? target : seqAddr;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= CBDU_IDLE;
      nextPc      <= WIDTH'(`CBDU_PC_RESET);
      branchTaken <= 1'b0;
    end else begin
      state       <= next_state;
      nextPc      <= next_nextPc;
      branchTaken <= next_branchTaken;
    end
  end

  // Both pulses are decoded from the state register; they can glitch when IDLE and FAULT swap both bits
  assign pcValid         = (state == CBDU_RESULT);
  assign misalignedFault = (state == CBDU_FAULT);

  sequence s_ltu_taken;
    isBranch && kind == CBDU_KIND_LTU && lessUnsigned && target[1:0] == 2'b00;
  endsequence

  sequence s_ne_taken;
    isBranch && kind == CBDU_KIND_NE && notEqual && target[1:0] == 2'b00;
  endsequence

  a_ltu_taken_pc: assert property (  // [RULE1]
    @(posedge mclk) disable iff (!rst_n)
    s_ltu_taken |=> pcValid && branchTaken && nextPc == $past(target))
    else $error("unsigned less branch did not reach its target");

  a_ltu_fall_through: assert property (  // [RULE1]
    @(posedge mclk) disable iff (!rst_n)
    isBranch && kind == CBDU_KIND_LTU && !lessUnsigned
    |=> pcValid && !branchTaken && nextPc == $past(instrAddr) + 32'h4)
    else $error("unsigned less branch should fall through");

  a_ne_taken_pc: assert property (  // [RULE2]
    @(posedge mclk) disable iff (!rst_n)
    s_ne_taken |=> pcValid && branchTaken)
    else $error("not equal branch not taken");

  a_eq_no_branch: assert property (  // [RULE2]
    @(posedge mclk) disable iff (!rst_n)
    isBranch && kind == CBDU_KIND_NE && firstSourceOperand == secondSourceOperand
    |=> !branchTaken && nextPc == $past(instrAddr) + 32'h4)
    else $error("equal operands must not branch");

  a_target_sum: assert property (  // [RULE3]
    @(posedge mclk) disable iff (!rst_n)
    s_ltu_taken
    |=> nextPc == $past(instrAddr) + 32'h4 + {{16{$past(instrWord[21])}}, $past(instrWord[21:6])})
    else $error("taken target not PC plus 4 plus offset");

  a_index_fields: assert property (  // [RULE9]
    @(posedge mclk) disable iff (!rst_n)
    firstIndex == instrWord[31:27] && secondIndex == instrWord[26:22])
    else $error("register index fields misplaced");

  a_misalign_fault: assert property (  // [RULE6]
    @(posedge mclk) disable iff (!rst_n)
    isBranch && takeCond && target[1:0] != 2'b00 |=> misalignedFault && !pcValid)
    else $error("misaligned target did not fault");

  a_fault_holds_pc: assert property (  // [RULE10]
    @(posedge mclk) disable iff (!rst_n)
    misalignedFault |-> $stable(nextPc) && !branchTaken)
    else $error("PC changed on misaligned fault");

  a_non_branch_quiet: assert property (  // [RULE7]
    @(posedge mclk) disable iff (!rst_n)
    !isBranch |=> !pcValid && !misalignedFault)
    else $error("non-branch word produced a result");

  // One outcome per accepted word, never both
  a_pulse_exclusive: assert property (  // [RULE10]
    @(posedge mclk) disable iff (!rst_n)
    !(pcValid && misalignedFault))
    else $error("result and fault raised together");

  a_ne_target_sum: assert property (  // [RULE4]
    @(posedge mclk) disable iff (!rst_n)
    s_ne_taken |=> nextPc ==
      $past(instrAddr) + 32'h4 + {{16{$past(instrWord[21])}}, $past(instrWord[21:6])})
    else $error("not equal target not PC plus 4 plus offset");

  a_offset_sign: assert property (  // [RULE8]
    @(posedge mclk) disable iff (!rst_n)
    offsetExt == {{16{instrWord[21]}}, instrWord[21:6]})
    else $error("offset not sign extended");

  a_taken_needs_result: assert property (  // [RULE6]
    @(posedge mclk) disable iff (!rst_n)
    branchTaken |-> pcValid && !misalignedFault)
    else $error("taken flag outside a result");

  sequence s_untaken;
    isBranch && !takeCond;
  endsequence

  a_untaken_no_fault: assert property (  // [RULE6]
    @(posedge mclk) disable iff (!rst_n)
    s_untaken |=> pcValid && !branchTaken && !misalignedFault)
    else $error("untaken branch faulted or was taken");

  a_refused_holds_pc: assert property (  // [RULE7]
    @(posedge mclk) disable iff (!rst_n)
    !isBranch |=> $stable(nextPc))
    else $error("ignored word moved the PC");

  a_opcode_decode: assert property (  // [RULE1]
    @(posedge mclk) disable iff (!rst_n)
    isBranch |-> instrValid
      && (opcode == `CBDU_OP_LESS_UNSIGNED || opcode == `CBDU_OP_NOT_EQUAL))
    else $error("branch decoded from another opcode");

endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
`include "cbdu_defines.svh"
module tb_top;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        instrValid = 1'b0;
  logic [31:0] instrWord = 32'h0;
  logic [31:0] instrAddr = 32'h0;
  logic [31:0] opA = 32'h0;
  logic [31:0] opB = 32'h0;
  logic [4:0]  firstIndex;
  logic [4:0]  secondIndex;
  logic        isBranch;
  logic        pcValid;
  logic        branchTaken;
  logic        misalignedFault;
  logic [31:0] nextPc;
  logic        expPv = 1'b0;
  logic        expFault = 1'b0;
  logic        expTaken = 1'b0;
  logic [31:0] expPc = 32'h0;
  int          badCount = 0;
  int          testsRun = 0;

  always #5 mclk = ~mclk;

  cbdu_branch_unit cbdu_branch_unit_inst (
    .mclk(mclk), .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
    .instrAddr(instrAddr), .firstSourceOperand(opA), .secondSourceOperand(opB),
    .firstIndex(firstIndex), .secondIndex(secondIndex), .isBranch(isBranch),
    .pcValid(pcValid), .nextPc(nextPc), .branchTaken(branchTaken),
    .misalignedFault(misalignedFault)
  );

  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic outs();
    chk("pcValid", expPv, pcValid);
    chk("misalignedFault", expFault, misalignedFault);
    chk("branchTaken", expTaken, branchTaken);
    chk("nextPc", expPc, nextPc);
  endtask

  // Outputs of the previous word are judged while this word is presented
  task automatic issue(logic v, logic [5:0] op, logic [15:0] off, logic [31:0] addr, a, b);
    logic [31:0] t;
    logic        br;
    logic        tk;
    t = addr + 32'h4 + {{16{off[15]}}, off};
    br = v && (op == `CBDU_OP_LESS_UNSIGNED || op == `CBDU_OP_NOT_EQUAL);
    tk = (op == `CBDU_OP_LESS_UNSIGNED) ? (a < b) : (a != b);
    @(posedge mclk);
    instrValid <= v;
    instrWord <= {a[4:0], b[9:5], off, op};
    instrAddr <= addr;
    opA <= a;
    opB <= b;
    @(negedge mclk);
    outs();
    chk("firstIndex", {27'h0, a[4:0]}, {27'h0, firstIndex});
    chk("secondIndex", {27'h0, b[9:5]}, {27'h0, secondIndex});
    chk("isBranch", {31'h0, br}, {31'h0, isBranch});
    expFault = br && tk && t[1:0] != 2'h0;
    expPv = br && !expFault;
    expTaken = expPv && tk;
    if (expPv) expPc = tk ? t : addr + 32'h4;
  endtask

  task automatic idle();
    @(posedge mclk);
    instrValid <= 1'b0;
    @(negedge mclk);
    outs();
    expPv = 1'b0;
    expFault = 1'b0;
    expTaken = 1'b0;
  endtask

  // Offsets kept word aligned here, as encoding software must do
  task automatic test_ltu();
    issue(1'b1, 6'h36, 16'h0010, 32'h100, 32'h0, 32'hffffffff);
    issue(1'b1, 6'h36, 16'h0010, 32'h100, 32'hffffffff, 32'h0);
    issue(1'b1, 6'h36, 16'h0020, 32'h140, 32'h5, 32'h5);
    issue(1'b1, 6'h36, 16'hfff0, 32'h200, 32'h1, 32'h2);
    idle();
    $display("test_ltu done");
  endtask

  task automatic test_ne();
    issue(1'b1, 6'h1e, 16'h7ffc, 32'h0, 32'h80000000, 32'h0);
    issue(1'b1, 6'h1e, 16'h8000, 32'h10000, 32'h3e3, 32'h3e3);
    issue(1'b1, 6'h1e, 16'h8000, 32'h10000, 32'h1, 32'h3);
    issue(1'b1, 6'h1e, 16'h0004, 32'hfffffffc, 32'h7, 32'h8);
    idle();
    $display("test_ne done");
  endtask

  task automatic test_misalign();
    issue(1'b1, 6'h36, 16'h0001, 32'h100, 32'h0, 32'h1);
    issue(1'b1, 6'h1e, 16'h0002, 32'h100, 32'h0, 32'h1);
    issue(1'b1, 6'h36, 16'h0003, 32'h100, 32'h1, 32'h0);
    idle();
    $display("test_misalign done");
  endtask

  task automatic test_refused();
    issue(1'b0, 6'h36, 16'h0040, 32'h400, 32'h0, 32'h1);
    issue(1'b1, 6'h16, 16'h0040, 32'h400, 32'h0, 32'h1);
    issue(1'b1, 6'h06, 16'h0040, 32'h400, 32'h2, 32'h1);
    idle();
    $display("test_refused done");
  endtask

  // Result is judged before reset; a branch follows right after release
  task automatic test_reset();
    issue(1'b1, 6'h36, 16'h0040, 32'h300, 32'h0, 32'h1);
    idle();
    @(posedge mclk);
    rst_n <= 1'b0;
    @(negedge mclk);
    expPc = 32'h0;
    outs();
    @(posedge mclk);
    rst_n <= 1'b1;
    issue(1'b1, 6'h1e, 16'h0008, 32'h40, 32'h1, 32'h2);
    idle();
    $display("test_reset done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    outs();
    @(posedge mclk);
    rst_n <= 1'b1;
    test_ltu();
    test_ne();
    test_misalign();
    test_refused();
    test_reset();
    conclude();
  end

  // About 35 cycles of traffic; allow ample margin
  initial begin
    #20000;
    badCount++;
    conclude();
  end
endmodule
